/* File: logic/fsos_sequencer.sv */
// output sequencer: dma stream in, simulated camera video out on the link clock
`timescale 1ns/1ps
module fsos_sequencer
	import fsos_pkg::*;
#(
	parameter int FIFO_DEPTH = fsos_pkg::FSOS_FIFO_DEPTH,
	parameter int PRIME_WORDS = fsos_pkg::FSOS_PRIME_WORDS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [fsos_pkg::FSOS_DATA_W-1:0] dma_data_i,
	input wire logic dma_valid_i,
	output logic dma_ready_o,
	input wire logic enable_i,
	input wire fsos_pkg::fsos_cfg_s cfg_i,
	output logic fval_event_o,
	output logic busy_o,
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	output fsos_pkg::fsos_video_s video_o
);
	import fsos_pkg::*;

	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	initial begin
		if (PRIME_WORDS < 1 || PRIME_WORDS > FIFO_DEPTH)
			$error("fsos_sequencer: PRIME_WORDS must lie in 1..FIFO_DEPTH");
	end

	// ************************************************************
	// data buffer between host clock and link clock
	// ************************************************************
	logic [FSOS_DATA_W-1:0] fifo_data;
	logic fifo_valid, fifo_ready;
	logic [LW-1:0] fifo_level;

	fsos_fifo #(.WIDTH(FSOS_DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.wclk_i(clk_i),
		.wrst_i(rst_i),
		.wdata_i(dma_data_i),
		.wvalid_i(dma_valid_i),
		.wready_o(dma_ready_o),
		.rclk_i(link_clk_i),
		.rrst_i(link_rst_i),
		.rdata_o(fifo_data),
		.rvalid_o(fifo_valid),
		.rready_i(fifo_ready),
		.rlevel_o(fifo_level)
	);

	// ************************************************************
	// crossings into the link domain
	// ************************************************************
	logic en_s1_r, en_s2_r;
	fsos_cfg_s cfg_s1_r, cfg_s2_r, cfg_s3_r;
	logic cfg_steady;

	// cfg is quasi-static; a start waits until two synced samples agree,
	// so a word caught mid-change is never latched
	always_ff @(posedge link_clk_i or posedge link_rst_i) begin
		if (link_rst_i) begin
			en_s1_r <= 1'b0;
			en_s2_r <= 1'b0;
			cfg_s1_r <= '0;
			cfg_s2_r <= '0;
			cfg_s3_r <= '0;
		end else begin
			en_s1_r <= enable_i;
			en_s2_r <= en_s1_r;
			cfg_s1_r <= cfg_i;
			cfg_s2_r <= cfg_s1_r;
			cfg_s3_r <= cfg_s2_r;
		end
	end

	assign cfg_steady = (cfg_s2_r == cfg_s3_r);

	// ************************************************************
	// line and frame sequencing
	// ************************************************************
	fsos_state_e st_r, st_nxt;
	fsos_cfg_s act_r, act_nxt;
	logic [FSOS_DIM_W-1:0] col_r, col_nxt, row_r, row_nxt;
	logic [FSOS_GAP_W-1:0] gap_r, gap_nxt;
	logic ev_tgl_r, ev_tgl_nxt;
	fsos_video_s vid_r, vid_nxt;
	logic in_img, last_col, primed;
	logic [FSOS_DIM_W:0] img_end;

	assign primed = fifo_level >= LW'(PRIME_WORDS);
	assign img_end = {1'b0, act_r.hstart} + {1'b0, act_r.img_width};
	assign in_img = ({1'b0, col_r} >= {1'b0, act_r.hstart}) && ({1'b0, col_r} < img_end);
	assign last_col = (col_r == act_r.line_len - 16'h0001);
	assign fifo_ready = (st_r == FSOS_LINE) && in_img;

	always_comb begin
		st_nxt = st_r;
		act_nxt = act_r;
		col_nxt = col_r;
		row_nxt = row_r;
		gap_nxt = gap_r;
		ev_tgl_nxt = ev_tgl_r;
		vid_nxt = '0;
		case (st_r)
			FSOS_IDLE: begin
				if (en_s2_r)
					st_nxt = FSOS_PRIME;
			end
			FSOS_PRIME: begin
				if (!en_s2_r) begin
					st_nxt = FSOS_IDLE;
				end else if (primed && cfg_steady && cfg_s2_r.line_len != '0 && cfg_s2_r.img_height != '0) begin
					act_nxt = cfg_s2_r;
					ev_tgl_nxt = ~ev_tgl_r;
					col_nxt = '0;
					row_nxt = '0;
					st_nxt = FSOS_LINE;
				end
			end
			FSOS_LINE: begin
				// a starved image pixel stalls the line rather than emit garbage
				if (!in_img || fifo_valid) begin
					vid_nxt.fval = 1'b1;
					vid_nxt.lval = 1'b1;
					vid_nxt.dval = 1'b1;
					if (in_img)
						vid_nxt.pixel = fifo_data[FSOS_PIX_W-1:0];
					else if (col_r < act_r.hstart)
						vid_nxt.pixel = act_r.fill_left;
					else
						vid_nxt.pixel = act_r.fill_right;
					col_nxt = col_r + 16'h0001;
					if (last_col) begin
						col_nxt = '0;
						row_nxt = row_r + 16'h0001;
						if (row_r == act_r.img_height - 16'h0001) begin
							gap_nxt = '0;
							st_nxt = FSOS_GAP;
						end
					end
				end else begin
					vid_nxt.fval = 1'b1;
				end
			end
			FSOS_GAP: begin
				gap_nxt = gap_r + 24'h00_0001;
				if (gap_nxt >= act_r.vgap)
					st_nxt = FSOS_PRIME;
			end
			default: st_nxt = FSOS_IDLE;
		endcase
	end

	always_ff @(posedge link_clk_i or posedge link_rst_i) begin
		if (link_rst_i) begin
			st_r <= FSOS_IDLE;
			act_r <= '0;
			col_r <= '0;
			row_r <= '0;
			gap_r <= '0;
			ev_tgl_r <= 1'b0;
			vid_r <= '0;
		end else begin
			st_r <= st_nxt;
			act_r <= act_nxt;
			col_r <= col_nxt;
			row_r <= row_nxt;
			gap_r <= gap_nxt;
			ev_tgl_r <= ev_tgl_nxt;
			vid_r <= vid_nxt;
		end
	end

	assign video_o = vid_r;

	// ************************************************************
	// frame-valid event back to the host clock
	// ************************************************************
	logic ev_s1_r, ev_s2_r, ev_s3_r, busy_s1_r, busy_s2_r;
	logic ev_pulse_nxt;

	always_comb begin
		ev_pulse_nxt = ev_s2_r ^ ev_s3_r;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ev_s1_r <= 1'b0;
			ev_s2_r <= 1'b0;
			ev_s3_r <= 1'b0;
			fval_event_o <= 1'b0;
			busy_s1_r <= 1'b0;
			busy_s2_r <= 1'b0;
		end else begin
			ev_s1_r <= ev_tgl_r;
			ev_s2_r <= ev_s1_r;
			ev_s3_r <= ev_s2_r;
			fval_event_o <= ev_pulse_nxt;
			busy_s1_r <= vid_r.fval;
			busy_s2_r <= busy_s1_r;
		end
	end

	assign busy_o = busy_s2_r;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_frame_start;
		(st_r == FSOS_PRIME) && (st_nxt == FSOS_LINE);
	endsequence

	a_prime_gate: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		s_frame_start |-> primed)
		else $error("frame started before buffer was primed");

	a_fval_toggle: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		s_frame_start |=> (ev_tgl_r != $past(ev_tgl_r)))
		else $error("frame start did not toggle the event");

	a_event_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		fval_event_o |=> !fval_event_o)
		else $error("frame event longer than one cycle");

	a_cfg_latch: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		s_frame_start |=> (act_r == $past(cfg_s2_r)))
		else $error("settings not latched at frame start");

	a_left_fill: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		(st_r == FSOS_LINE && col_r < act_r.hstart) |=> (video_o.pixel == act_r.fill_left && video_o.dval))
		else $error("left margin pixel wrong");

	a_right_fill: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		(st_r == FSOS_LINE && {1'b0, col_r} >= img_end) |=> (video_o.pixel == act_r.fill_right))
		else $error("right margin pixel wrong");

	a_image_place: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		(st_r == FSOS_LINE && in_img && fifo_valid) |=> (video_o.pixel == $past(fifo_data[FSOS_PIX_W-1:0])))
		else $error("image pixel not taken from buffer");

	a_gap_len: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		(st_r == FSOS_GAP && gap_nxt < act_r.vgap) |=> (st_r == FSOS_GAP))
		else $error("vertical gap ended early");

	a_fval_drop: assert property (@(posedge link_clk_i) disable iff (link_rst_i)
		(st_r == FSOS_LINE && st_nxt == FSOS_GAP) |=> ##1 !video_o.fval)
		else $error("frame-valid held into the gap");
endmodule : fsos_sequencer

/* File: logic/fsos_pkg.sv */
// package for the frame simulator output sequencer
package fsos_pkg;
	localparam int FSOS_PIX_W = 24;
	localparam int FSOS_DIM_W = 16;
	localparam int FSOS_GAP_W = 24;
	localparam int FSOS_DATA_W = 32;
	localparam int FSOS_BYTES_PER_WORD = 4;
	// 16 KB of image data held before the first pixel leaves
	localparam int FSOS_PRIME_BYTES = 16384;
	localparam int FSOS_PRIME_WORDS = FSOS_PRIME_BYTES / FSOS_BYTES_PER_WORD;
	localparam int FSOS_FIFO_DEPTH = 8192;
	localparam logic [FSOS_GAP_W-1:0] FSOS_VGAP_DEFAULT = 24'h00_0190;
	localparam logic [FSOS_DIM_W-1:0] FSOS_DIM_RESET = 16'h0000;

	// per-image settings, latched at frame start, one link cycle before frame-valid rises
	typedef struct packed {
		logic [FSOS_DIM_W-1:0] line_len;
		logic [FSOS_DIM_W-1:0] img_width;
		logic [FSOS_DIM_W-1:0] img_height;
		logic [FSOS_DIM_W-1:0] hstart;
		logic [FSOS_PIX_W-1:0] fill_left;
		logic [FSOS_PIX_W-1:0] fill_right;
		logic [FSOS_GAP_W-1:0] vgap;
	} fsos_cfg_s;

	// one video beat toward the grabber
	typedef struct packed {
		logic fval;
		logic lval;
		logic dval;
		logic [FSOS_PIX_W-1:0] pixel;
	} fsos_video_s;

	typedef enum logic [1:0] {
		FSOS_IDLE = 2'b00,
		FSOS_PRIME = 2'b01,
		FSOS_LINE = 2'b10,
		FSOS_GAP = 2'b11
	} fsos_state_e;
endpackage : fsos_pkg

/* File: logic/fsos_fifo.sv */
// dual-clock fifo with gray pointers, plus a two-entry output skid buffer
`timescale 1ns/1ps
module fsos_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8192
) (
	input wire logic wclk_i,
	input wire logic wrst_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic wvalid_i,
	output logic wready_o,
	input wire logic rclk_i,
	input wire logic rrst_i,
	output logic [WIDTH-1:0] rdata_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic [$clog2(DEPTH):0] rlevel_o
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 4 || (1 << AW) != DEPTH)
			$error("fsos_fifo: DEPTH must be a power of two, at least 4");
	end

	function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction : bin2gray

	function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
		logic [AW:0] b;
		b = '0;
		for (int i = AW; i >= 0; i--) begin
			b[i] = (i == AW) ? g[i] : (b[i+1] ^ g[i]);
		end
		gray2bin = b;
	endfunction : gray2bin

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin_r, wbin_nxt, wgray_r, rbin_r, rbin_nxt, rgray_r;
	logic [AW:0] rg_w1_r, rg_w2_r, wg_r1_r, wg_r2_r;
	logic [WIDTH-1:0] sk_data_r [2];
	logic [WIDTH-1:0] sk_data_nxt [2];
	logic [1:0] sk_cnt_r, sk_cnt_nxt;
	logic [AW:0] wbin_rd, used;
	logic do_wr, do_rd, pop;

	// ************************************************************
	// write side
	// ************************************************************
	assign wready_o = (wgray_r != {~rg_w2_r[AW:AW-1], rg_w2_r[AW-2:0]});
	assign do_wr = wvalid_i && wready_o;

	always_comb begin
		wbin_nxt = do_wr ? wbin_r + 1'b1 : wbin_r;
	end

	always_ff @(posedge wclk_i or posedge wrst_i) begin
		if (wrst_i) begin
			wbin_r <= '0;
			wgray_r <= '0;
			rg_w1_r <= '0;
			rg_w2_r <= '0;
		end else begin
			wbin_r <= wbin_nxt;
			wgray_r <= bin2gray(wbin_nxt);
			rg_w1_r <= rgray_r;
			rg_w2_r <= rg_w1_r;
		end
	end

	always_ff @(posedge wclk_i) begin
		if (do_wr)
			mem[wbin_r[AW-1:0]] <= wdata_i;
	end

	// ************************************************************
	// read side, drained into a two-entry skid buffer
	// ************************************************************
	assign wbin_rd = gray2bin(wg_r2_r);
	assign used = wbin_rd - rbin_r;
	assign pop = rvalid_o && rready_i;
	assign do_rd = (used != '0) && ((sk_cnt_r - {1'b0, pop}) < 2'd2);
	assign rvalid_o = (sk_cnt_r != 2'd0);
	assign rdata_o = sk_data_r[0];
	assign rlevel_o = used + {{(AW-1){1'b0}}, sk_cnt_r};

	always_comb begin
		rbin_nxt = do_rd ? rbin_r + 1'b1 : rbin_r;
		sk_data_nxt = sk_data_r;
		sk_cnt_nxt = sk_cnt_r;
		if (pop) begin
			sk_data_nxt[0] = sk_data_r[1];
			sk_cnt_nxt = sk_cnt_nxt - 2'd1;
		end
		if (do_rd) begin
			sk_data_nxt[sk_cnt_nxt[0]] = mem[rbin_r[AW-1:0]];
			sk_cnt_nxt = sk_cnt_nxt + 2'd1;
		end
	end

	always_ff @(posedge rclk_i or posedge rrst_i) begin
		if (rrst_i) begin
			rbin_r <= '0;
			rgray_r <= '0;
			wg_r1_r <= '0;
			wg_r2_r <= '0;
			sk_cnt_r <= 2'd0;
			sk_data_r[0] <= '0;
			sk_data_r[1] <= '0;
		end else begin
			rbin_r <= rbin_nxt;
			rgray_r <= bin2gray(rbin_nxt);
			wg_r1_r <= wgray_r;
			wg_r2_r <= wg_r1_r;
			sk_cnt_r <= sk_cnt_nxt;
			sk_data_r <= sk_data_nxt;
		end
	end
endmodule : fsos_fifo

/* File: testbench/fsos_grabber.sv */
// frame grabber model: takes video beats on the link clock
`timescale 1ns/1ps
module fsos_grabber (
	input wire logic link_clk_i,
	input wire logic link_rst_i,
	input wire fsos_pkg::fsos_video_s video_i,
	output logic [15:0] gap_o
);
	import fsos_pkg::*;
	// ****************
	// capture
	// ****************
	logic [FSOS_PIX_W-1:0] pixq[$];
	logic [15:0] low_r;
	logic fval_r;
	// only data-valid beats inside a frame are kept
	always @(posedge link_clk_i or posedge link_rst_i) begin
		if (link_rst_i) begin
			low_r <= 16'h0000;
			fval_r <= 1'b0;
			gap_o <= 16'h0000;
		end else begin
			fval_r <= video_i.fval;
			if (video_i.fval && video_i.dval) begin
				pixq.push_back(video_i.pixel);
			end
			// low cycles before each rise
			if (video_i.fval && !fval_r) begin
				gap_o <= low_r;
			end
			low_r <= video_i.fval ? 16'h0000 : low_r + 16'h0001;
		end
	end
endmodule : fsos_grabber

/* File: testbench/frame_sim_output_sequencer_bench.sv */
// bench for the output sequencer: dma feed, settings, frames and gaps
`timescale 1ns/1ps
module frame_sim_output_sequencer_bench;
	import fsos_pkg::*;
	localparam int PRIME = 8;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic link_clk_i = 1'b0;
	logic link_rst_i = 1'b1;
	logic [FSOS_DATA_W-1:0] dma_data_i = 32'h0000_0000;
	logic dma_valid_i = 1'b0;
	logic enable_i = 1'b0;
	fsos_cfg_s cfg_i = '0;
	logic dma_ready_o;
	logic fval_event_o;
	logic busy_o;
	fsos_video_s video_o;
	logic [15:0] gap;
	int failures = 0;
	int compares = 0;
	int events = 0;
	int sent = 0;
	fsos_cfg_s c1;
	fsos_cfg_s c2;

	fsos_sequencer #(.FIFO_DEPTH(16), .PRIME_WORDS(PRIME)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.dma_data_i(dma_data_i), .dma_valid_i(dma_valid_i), .dma_ready_o(dma_ready_o), .enable_i(enable_i),
		.cfg_i(cfg_i), .fval_event_o(fval_event_o), .busy_o(busy_o), .link_clk_i(link_clk_i),
		.link_rst_i(link_rst_i), .video_o(video_o));
	fsos_grabber i_grab (.link_clk_i(link_clk_i), .link_rst_i(link_rst_i), .video_i(video_o), .gap_o(gap));

	always #2.5 clk_i = ~clk_i;
	always #16 link_clk_i = ~link_clk_i;
	always @(posedge clk_i) begin
		if (fval_event_o === 1'b1) begin
			events++;
		end
	end

	// ****************
	// tasks
	// ****************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic results();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : results

	task automatic timeout(input string what);
		failures++;
		$display("[FAIL] %s expected done seen timeout", what);
		results();
	endtask : timeout

	task automatic push(input int n);
		int w;
		dma_valid_i = 1'b1;
		for (int i = 0; i < n; i++) begin
			dma_data_i = {8'hee, 24'h10_0000 + sent[23:0]};
			for (w = 0; w < 50 && dma_ready_o !== 1'b1; w++) begin
				@(posedge clk_i);
				#1;
			end
			if (w == 50) begin
				timeout("dma ready");
			end
			@(posedge clk_i);
			#1;
			sent++;
		end
		dma_valid_i = 1'b0;
	endtask : push

	task automatic wait_event(input int n);
		for (int w = 0; w < 400 && events < n; w++) begin
			@(posedge clk_i);
			#1;
		end
		if (events < n) begin
			timeout("frame event");
		end
	endtask : wait_event

	task automatic check_frame(input fsos_cfg_s c, inout int k);
		for (int l = 0; l < c.img_height; l++) begin
			for (int x = 0; x < c.line_len; x++) begin
				logic [23:0] e;
				e = x < c.hstart ? c.fill_left : c.fill_right;
				if (x >= c.hstart && x < c.hstart + c.img_width) begin
					e = 24'h10_0000 + k[23:0];
					k++;
				end
				chk("frame pixel", i_grab.pixq.pop_front(), e);
			end
		end
	endtask : check_frame

	// prime hold, two frames, settings swapped mid-frame
	task automatic test_frames();
		int k;
		k = 0;
		cfg_i = c1;
		enable_i = 1'b1;
		push(PRIME - 1);
		repeat (100) @(posedge clk_i);
		#1;
		chk("events before prime", events, 0);
		chk("pixels before prime", i_grab.pixq.size(), 0);
		push(1);
		wait_event(1);
		// busy trails frame-valid by a two-flop host-clock sync
		for (int w = 0; w < 40 && busy_o !== 1'b1; w++) begin
			@(posedge clk_i);
			#1;
		end
		chk("busy at frame", busy_o, 1);
		cfg_i = c2;
		push(8);
		wait_event(2);
		enable_i = 1'b0;
		// grabber logs the gap once it samples the new frame-valid
		repeat (3) @(posedge link_clk_i);
		@(posedge clk_i);
		#1;
		chk("gap in range", gap >= c1.vgap && gap <= c1.vgap + 4, 1);
		for (int w = 0; w < 400 && busy_o !== 1'b0; w++) begin
			@(posedge clk_i);
			#1;
		end
		chk("busy drops", busy_o, 0);
		chk("event count", events, 2);
		chk("pixel count", i_grab.pixq.size(), 17);
		check_frame(c1, k);
		check_frame(c2, k);
		$display("test frames done");
	endtask : test_frames

	// fill while idle until the buffer refuses
	task automatic test_refuse();
		int n;
		dma_valid_i = 1'b1;
		for (n = 0; n < 40 && dma_ready_o === 1'b1; n++) begin
			dma_data_i = {8'hee, 24'h10_0000 + sent[23:0]};
			@(posedge clk_i);
			#1;
		end
		dma_valid_i = 1'b0;
		chk("buffer refuses", dma_ready_o, 0);
		repeat (50) @(posedge clk_i);
		#1;
		chk("idle while disabled", busy_o, 0);
		chk("no extra events", events, 2);
		$display("test refuse done");
	endtask : test_refuse

	initial begin
		c1 = {16'h0006, 16'h0002, 16'h0002, 16'h0001, 24'h00_00a1, 24'h00_00b2, 24'h00_000a};
		c2 = {16'h0005, 16'h0003, 16'h0001, 16'h0000, 24'h00_00c3, 24'h00_00d4, 24'h00_000c};
		// host side: offset and fills of -1 resolved before programming
		c2.hstart = (c2.line_len - c2.img_width) / 16'h0002;
		c2.fill_left = 24'h10_0004;
		c2.fill_right = 24'h10_0006;
		repeat (3) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		repeat (2) @(posedge link_clk_i);
		#1;
		link_rst_i = 1'b0;
		@(posedge clk_i);
		#1;
		test_frames();
		test_refuse();
		results();
	end
endmodule : frame_sim_output_sequencer_bench
